// ==== design/uedr_map.vh ====
`ifndef UEDR_MAP_VH
`define UEDR_MAP_VH

// Register layout, one block of words per endpoint
`define UEDR_EP_STRIDE   8'h10
`define UEDR_CTRL_OFS    4'h0
`define UEDR_INTVL_OFS   4'h4
`define UEDR_STAT_OFS    4'h8

// Fields of endpoint_dma_control
`define UEDR_CTRL_EN     0
`define UEDR_CTRL_MODE   1
`define UEDR_CTRL_WIDTH  2
`define UEDR_CTRL_TX     3
`define UEDR_CTRL_ISO    4
`define UEDR_CTRL_BITS   5
`define UEDR_CTRL_RST    5'h00
`define UEDR_INTVL_RST   16'h0000

// Request mode encodings
`define UEDR_MODE_SINGLE 1'b0
`define UEDR_MODE_DEMAND 1'b1

// Fields of the status word
`define UEDR_STAT_COUNT  0
`define UEDR_STAT_RXRDY  16
`define UEDR_STAT_TXRDY  17
`define UEDR_STAT_REQ    18
`define UEDR_STAT_RECOV  19
`define UEDR_STAT_STATE  20

// FIFO sizes in bytes
`define UEDR_SMALL_DEPTH 64
`define UEDR_LARGE_DEPTH 256

// Counter recovery waits in system clocks
`define UEDR_RECOV_8     2'd1
`define UEDR_RECOV_16    2'd2

`endif

// ==== design/uedr_fifo_cnt.v ====
`timescale 1ns/1ps
`include "uedr_map.vh"

module uedr_fifo_cnt
#(
	parameter integer DEPTH = `UEDR_SMALL_DEPTH,
	parameter integer CW    = 9
)
(
	input  wire          clk,
	input  wire          rst,
	input  wire          tx,
	input  wire          wide,
	input  wire          acc,
	input  wire          usb_byte,
	output reg  [CW-1:0] count,
	output reg           empty,
	output reg           full,
	output reg           busy
);
	localparam [CW:0] DEPTH_W = DEPTH[CW:0];

	reg  [CW:0] up;
	reg  [CW:0] down;
	reg  [CW:0] sum;
	reg  [CW:0] next_count;
	reg  [1:0]  wcnt;
	reg  [1:0]  next_wcnt;
	wire [CW:0] step = wide ? {{(CW-1){1'b0}}, 2'd2} : {{CW{1'b0}}, 1'b1};

	// Byte occupancy: one side adds, the other removes, width sets the step
	always @*
	begin
		up   = tx ? (acc ? step : {(CW+1){1'b0}}) : {{CW{1'b0}}, usb_byte};
		down = tx ? {{CW{1'b0}}, usb_byte} : (acc ? step : {(CW+1){1'b0}});
		sum  = {1'b0, count} + up;
		if (sum < down)
			next_count = {(CW+1){1'b0}};
		else if (sum - down > DEPTH_W)
			next_count = DEPTH_W;
		else
			next_count = sum - down;
		if (acc)
			next_wcnt = wide ? `UEDR_RECOV_16 : `UEDR_RECOV_8;
		else if (wcnt != 2'd0)
			next_wcnt = wcnt - 2'd1;
		else
			next_wcnt = 2'd0;
	end

	// Count, flags and recovery hold
	always @(posedge clk)
	begin
		if (rst)
		begin
			count <= {CW{1'b0}};
			empty <= 1'b1;
			full  <= 1'b0;
			wcnt  <= 2'd0;
			busy  <= 1'b0;
		end
		else
		begin
			count <= next_count[CW-1:0];
			empty <= (next_count == {(CW+1){1'b0}});
			full  <= (next_count == DEPTH_W);
			wcnt  <= next_wcnt;
			busy  <= (next_wcnt != 2'd0);
		end
	end
endmodule // uedr_fifo_cnt

// ==== design/uedr_gap_timer.v ====
`timescale 1ns/1ps

module uedr_gap_timer
#(
	parameter integer W = 16
)
(
	input  wire         clk,
	input  wire         rst,
	input  wire         load,
	input  wire [W-1:0] value,
	output reg          expire
);
	reg [W-1:0] cnt;
	reg         running;

	// Counts the loaded interval down, then gives a one-cycle pulse
	always @(posedge clk)
	begin
		if (rst)
		begin
			cnt     <= {W{1'b0}};
			running <= 1'b0;
			expire  <= 1'b0;
		end
		else if (load)
		begin
			cnt     <= value;
			running <= 1'b1;
			expire  <= 1'b0;
		end
		else if (running && cnt == {W{1'b0}})
		begin
			running <= 1'b0;
			expire  <= 1'b1;
		end
		else
		begin
			expire <= 1'b0;
			if (running)
				cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // uedr_gap_timer

// ==== design/uedr_top.v ====
// Contract
// - Only the two endpoints have DMA requests, each with its own FIFO and request output.
// - A DMA read that empties the FIFO clears that endpoint's receive-ready flag.
// - A DMA write that fills the FIFO to its size sets that endpoint's transmit-ready flag.
// - Isochronous transfers ignore the programmed request interval.
// - A receive request ends once every byte of the receive FIFO is read.
// - A transmit request ends when the FIFO is full, 64 or 256 bytes.
// - Bulk receive starts a request after a packet is received without error.
// - Isochronous receive starts after a nonempty good packet and then a start of frame.
// - Bulk transmit starts on an empty FIFO; isochronous transmit starts on start of frame.
// - Demand mode holds the request up until the end condition, ignoring the interval. The code still drops it in each access cycle and during recovery.
// - Single mode drops the request per access, waits the interval, and reasserts.
// - The width field sets the width of both DMA and program FIFO accesses.
// - Each FIFO access is followed by one clock of recovery for 8 bits and two for 16.
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "uedr_map.vh"

module uedr_top
#(
	parameter integer IW = 16
)
(
	input  wire        SYS_CLK,
	input  wire        SYS_RST,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [7:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	input  wire        USB_SOF,
	input  wire [1:0]  USB_RX_BYTE,
	input  wire [1:0]  USB_RX_DONE,
	input  wire [1:0]  USB_TX_BYTE,
	input  wire [1:0]  USB_TX_SENT,
	input  wire [1:0]  SYS_DMA_ACK,
	input  wire [1:0]  CPU_FIFO_ACC,
	output wire        EP_SMALL_TRANSFER_REQUEST,
	output wire        EP_LARGE_TRANSFER_REQUEST,
	output wire [1:0]  RX_PACKET_READY,
	output wire [1:0]  TX_PACKET_READY,
	output wire [1:0]  FIFO_RECOVERY
);
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_REQ  = 2'd1;
	localparam [1:0] ST_GAP  = 2'd2;
	localparam integer CW = 9;

	// Bus decode shared by both endpoint blocks
	wire        bus_req   = WB_CYC_I && WB_STB_I;
	wire        bus_map   = (WB_ADR_I[7:5] == 3'b000);
	wire        bus_ep    = WB_ADR_I[4];
	wire [3:0]  bus_reg   = WB_ADR_I[3:0];
	wire        bus_write = bus_req && WB_ACK_O && WB_WE_I && bus_map;
	wire [63:0] rd_ctrl;
	wire [63:0] rd_intvl;
	wire [63:0] rd_stat;
	wire [1:0]  req_flat;
	reg  [31:0] next_dat;

	assign EP_SMALL_TRANSFER_REQUEST = req_flat[0];
	assign EP_LARGE_TRANSFER_REQUEST = req_flat[1];

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1)
		begin : ep_g
			localparam integer DEPTH = (i == 0) ? `UEDR_SMALL_DEPTH : `UEDR_LARGE_DEPTH;

			reg  [`UEDR_CTRL_BITS-1:0] ctrl;
			reg  [IW-1:0]              intvl;
			reg  [1:0]                 state;
			reg  [1:0]                 next_state;
			reg                        req;
			reg                        rx_ready;
			reg                        tx_ready;
			reg                        iso_pend;
			reg                        dma_acc_d;
			reg                        load_gap;
			reg                        start;
			wire                       hit;
			wire                       en;
			wire                       single;
			wire                       wide;
			wire                       tx;
			wire                       iso;
			wire                       dma_acc;
			wire                       any_acc;
			wire                       done;
			wire                       gap_expire;
			wire [IW-1:0]              gap_value;
			wire [CW-1:0]              count;
			wire                       empty;
			wire                       full;
			wire                       busy;
			wire                       wr_ctrl;
			wire                       wr_intvl;
			wire                       act_bulk_rx;
			wire                       act_iso_rx;
			wire                       act_bulk_tx;
			wire                       act_iso_tx;
			reg                        next_rx_ready;
			reg                        next_tx_ready;
			reg                        next_iso_pend;
			reg                        next_req;
			reg  [31:0]                stat;

			assign hit      = bus_write && (bus_ep == ((i == 0) ? 1'b0 : 1'b1));
			assign wr_ctrl  = hit && (bus_reg == `UEDR_CTRL_OFS);
			assign wr_intvl = hit && (bus_reg == `UEDR_INTVL_OFS);
			assign en      = ctrl[`UEDR_CTRL_EN];
			assign single  = (ctrl[`UEDR_CTRL_MODE] == `UEDR_MODE_SINGLE);
			assign wide    = ctrl[`UEDR_CTRL_WIDTH];
			assign tx      = ctrl[`UEDR_CTRL_TX];
			assign iso     = ctrl[`UEDR_CTRL_ISO];
			assign dma_acc = SYS_DMA_ACK[i];
			assign any_acc = SYS_DMA_ACK[i] || CPU_FIFO_ACC[i];

			// Receive ends when drained, transmit when full
			assign done = tx ? full : empty;

			// Isochronous gaps take no interval
			assign gap_value = iso ? {IW{1'b0}} : intvl;

			// Control and interval registers, byte-lane written
			always @(posedge SYS_CLK)
			begin
				if (SYS_RST)
				begin
					ctrl  <= `UEDR_CTRL_RST;
					intvl <= `UEDR_INTVL_RST;
				end
				else if (wr_ctrl)
				begin
					if (WB_SEL_I[0])
						ctrl <= WB_DAT_I[`UEDR_CTRL_BITS-1:0];
				end
				else if (wr_intvl)
				begin
					if (WB_SEL_I[0])
						intvl[7:0] <= WB_DAT_I[7:0];
					if (WB_SEL_I[1])
						intvl[IW-1:8] <= WB_DAT_I[IW-1:8];
				end
			end

			// Byte occupancy and access recovery; width covers DMA and CPU alike
			uedr_fifo_cnt
			#(
				.DEPTH (DEPTH),
				.CW    (CW)
			)
			u_cnt
			(
				.clk      (SYS_CLK),
				.rst      (SYS_RST),
				.tx       (tx),
				.wide     (wide),
				.acc      (any_acc),
				.usb_byte (tx ? USB_TX_BYTE[i] : USB_RX_BYTE[i]),
				.count    (count),
				.empty    (empty),
				.full     (full),
				.busy     (busy)
			);

			// Interval between single-mode requests
			uedr_gap_timer
			#(
				.W (IW)
			)
			u_gap
			(
				.clk    (SYS_CLK),
				.rst    (SYS_RST),
				.load   (load_gap),
				.value  (gap_value),
				.expire (gap_expire)
			);

			// Activation conditions, one per transfer type and direction
			assign act_bulk_rx = USB_RX_DONE[i];
			assign act_iso_rx  = iso_pend && USB_SOF;
			assign act_bulk_tx = empty && !tx_ready;
			assign act_iso_tx  = USB_SOF;

			// Activation depends on transfer type and direction
			always @*
			begin
				if (!tx && !iso)
					start = act_bulk_rx;
				else if (!tx)
					start = act_iso_rx;
				else if (!iso)
					start = act_bulk_tx;
				else
					start = act_iso_tx;
			end

			// Request state machine
			always @*
			begin
				next_state = state;
				load_gap   = 1'b0;
				case (state)
					ST_IDLE:
					begin
						if (en && start && !done)
							next_state = ST_REQ;
					end
					ST_REQ:
					begin
						if (!en || done)
							next_state = ST_IDLE;
						else if (single && dma_acc)
						begin
							next_state = ST_GAP;
							load_gap   = 1'b1;
						end
						else
							next_state = ST_REQ;
					end
					ST_GAP:
					begin
						if (!en || done)
							next_state = ST_IDLE;
						else if (gap_expire)
							next_state = ST_REQ;
					end
					default:
					begin
						next_state = ST_IDLE;
					end
				endcase
			end

			// Next flag values; a set beats a clear in the same cycle
			always @*
			begin
				next_rx_ready = rx_ready;
				next_tx_ready = tx_ready;
				next_iso_pend = iso_pend;
				if (!tx && USB_RX_DONE[i])
					next_rx_ready = 1'b1;
				else if (dma_acc_d && !tx && empty)
					next_rx_ready = 1'b0;
				if (dma_acc_d && tx && full)
					next_tx_ready = 1'b1;
				else if (USB_TX_SENT[i])
					next_tx_ready = 1'b0;
				if (USB_RX_DONE[i] && iso && !tx && !empty)
					next_iso_pend = 1'b1;
				else if (USB_SOF || !en)
					next_iso_pend = 1'b0;
				// Request masked in the access cycle and during recovery
				next_req = (next_state == ST_REQ) && !any_acc && !busy;
			end

			// State, request level and packet-ready flags
			always @(posedge SYS_CLK)
			begin
				if (SYS_RST)
				begin
					state     <= ST_IDLE;
					req       <= 1'b0;
					rx_ready  <= 1'b0;
					tx_ready  <= 1'b0;
					iso_pend  <= 1'b0;
					dma_acc_d <= 1'b0;
				end
				else
				begin
					state     <= next_state;
					req       <= next_req;
					dma_acc_d <= dma_acc;
					rx_ready  <= next_rx_ready;
					tx_ready  <= next_tx_ready;
					iso_pend  <= next_iso_pend;
				end
			end

			assign req_flat[i]        = req;
			assign RX_PACKET_READY[i] = rx_ready;
			assign TX_PACKET_READY[i] = tx_ready;
			assign FIFO_RECOVERY[i]   = busy;

			// Read words for this endpoint
			assign rd_ctrl[i*32 +: 32]  = {{(32-`UEDR_CTRL_BITS){1'b0}}, ctrl};
			assign rd_intvl[i*32 +: 32] = {{(32-IW){1'b0}}, intvl};
			assign rd_stat[i*32 +: 32]  = stat;

			// Status word assembled from its fields
			always @*
			begin
				stat                         = 32'h0000_0000;
				stat[`UEDR_STAT_COUNT +: CW] = count;
				stat[`UEDR_STAT_RXRDY]       = rx_ready;
				stat[`UEDR_STAT_TXRDY]       = tx_ready;
				stat[`UEDR_STAT_REQ]         = req;
				stat[`UEDR_STAT_RECOV]       = busy;
				stat[`UEDR_STAT_STATE +: 2]  = state;
			end
		end
	endgenerate

	// Read mux; unmapped offsets answer with zero
	always @*
	begin
		if (!bus_map)
			next_dat = 32'h0000_0000;
		else if (bus_reg == `UEDR_CTRL_OFS && !bus_ep)
			next_dat = rd_ctrl[31:0];
		else if (bus_reg == `UEDR_CTRL_OFS)
			next_dat = rd_ctrl[63:32];
		else if (bus_reg == `UEDR_INTVL_OFS && !bus_ep)
			next_dat = rd_intvl[31:0];
		else if (bus_reg == `UEDR_INTVL_OFS)
			next_dat = rd_intvl[63:32];
		else if (bus_reg == `UEDR_STAT_OFS && !bus_ep)
			next_dat = rd_stat[31:0];
		else if (bus_reg == `UEDR_STAT_OFS)
			next_dat = rd_stat[63:32];
		else
			next_dat = 32'h0000_0000;
	end

	// Classic Wishbone answer: ack one cycle after the request, for one cycle
	always @(posedge SYS_CLK)
	begin
		if (SYS_RST)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end
		else
		begin
			WB_ACK_O <= bus_req && !WB_ACK_O;
			WB_DAT_O <= (bus_req && !WB_ACK_O && !WB_WE_I) ? next_dat : 32'h0000_0000;
		end
	end
endmodule // uedr_top

// ==== dv/uedr_dma_model.sv ====
`timescale 1ns/1ps
// Far-side DMA engine: one access per held request
module uedr_dma_model
(
	input  wire       clk,
	input  wire       rst,
	input  wire [1:0] req,
	input  wire [3:0] dly,
	output reg  [1:0] ack
);
	reg [3:0] cnt [0:1];
	integer   i;
	// Answer after the request stood dly+1 cycles; never twice in a row
	always @(posedge clk)
		for (i = 0; i < 2; i = i + 1)
		begin
			ack[i] <= 1'b0;
			if (rst || !req[i] || ack[i])
				cnt[i] <= 4'h0;
			else if (cnt[i] == dly)
				ack[i] <= 1'b1;
			else
				cnt[i] <= cnt[i] + 4'h1;
		end
endmodule // uedr_dma_model

// ==== dv/uedr_top_monitor.sv ====
`timescale 1ns/1ps
module uedr_top_monitor
(
	input wire        SYS_CLK,
	input wire        SYS_RST,
	input wire        WB_STB_I,
	input wire        WB_ACK_O,
	input wire [1:0]  SYS_DMA_ACK,
	input wire        EP_SMALL_TRANSFER_REQUEST,
	input wire        EP_LARGE_TRANSFER_REQUEST,
	input wire [1:0]  RX_PACKET_READY,
	input wire [1:0]  TX_PACKET_READY,
	input wire [1:0]  FIFO_RECOVERY
);
	wire [1:0] req = {EP_LARGE_TRANSFER_REQUEST, EP_SMALL_TRANSFER_REQUEST};
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	property p_rst;
		$fell(SYS_RST) |-> req == 2'h0 && TX_PACKET_READY == 2'h0;
	endproperty
	property p_drop_s;
		SYS_DMA_ACK[0] |=> !req[0] ##1 !req[0];
	endproperty
	property p_drop_l;
		SYS_DMA_ACK[1] |=> !req[1] ##1 !req[1];
	endproperty
	property p_recov;
		SYS_DMA_ACK[0] |=> FIFO_RECOVERY[0];
	endproperty
	property p_recov_end;
		$rose(FIFO_RECOVERY[1]) |-> ##[1:2] !FIFO_RECOVERY[1];
	endproperty
	property p_wb;
		$rose(WB_STB_I) |=> WB_ACK_O ##1 !WB_ACK_O;
	endproperty
	property p_txrdy;
		$rose(TX_PACKET_READY[0]) |-> $past(SYS_DMA_ACK[0]) || $past(SYS_DMA_ACK[0], 2);
	endproperty
	property p_rxclr;
		$fell(RX_PACKET_READY[1]) |-> $past(SYS_DMA_ACK[1]) || $past(SYS_DMA_ACK[1], 2);
	endproperty
	a_rst: assert property (p_rst) else $error("output up after reset");
	a_drop_s: assert property (p_drop_s) else $error("small request kept");
	a_drop_l: assert property (p_drop_l) else $error("large request kept");
	a_recov: assert property (p_recov) else $error("no recovery");
	a_recov_end: assert property (p_recov_end) else $error("long recovery");
	a_wb: assert property (p_wb) else $error("bus ack not one pulse");
	a_txrdy: assert property (p_txrdy) else $error("tx ready without write");
	a_rxclr: assert property (p_rxclr) else $error("rx ready cleared alone");
	cover property ($rose(EP_SMALL_TRANSFER_REQUEST));
	cover property ($rose(TX_PACKET_READY[1]));
	cover property ($fell(RX_PACKET_READY[1]));
endmodule // uedr_top_monitor
bind uedr_top uedr_top_monitor u_mon
(
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
	.SYS_DMA_ACK(SYS_DMA_ACK), .EP_SMALL_TRANSFER_REQUEST(EP_SMALL_TRANSFER_REQUEST),
	.EP_LARGE_TRANSFER_REQUEST(EP_LARGE_TRANSFER_REQUEST), .RX_PACKET_READY(RX_PACKET_READY),
	.TX_PACKET_READY(TX_PACKET_READY), .FIFO_RECOVERY(FIFO_RECOVERY)
);

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         cyc = 1'b0;
	reg         stb = 1'b0;
	reg         we  = 1'b0;
	reg  [7:0]  adr = 8'h00;
	reg  [3:0]  sel = 4'h0;
	reg  [31:0] wd  = 32'h0;
	reg         sof = 1'b0;
	reg  [1:0]  rxb = 2'h0;
	reg  [1:0]  rxd = 2'h0;
	reg  [1:0]  txs = 2'h0;
	reg  [1:0]  txb = 2'h0;
	reg  [1:0]  cpu = 2'h0;
	reg  [3:0]  dly = 4'h0;
	reg  [31:0] q;
	wire [31:0] rd;
	wire        ack;
	wire [1:0]  dack;
	wire [1:0]  req;
	wire [1:0]  rxr;
	wire [1:0]  txr;
	wire [1:0]  rec;
	integer     n_fail = 0;
	integer     checks = 0;
	integer     ncyc = 0;
	integer     nacc = 0;
	integer     gap = 0;
	integer     gmin = 0;
	initial
		forever #12.5 clk = ~clk;
	uedr_top DUT
	(
		.SYS_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
		.USB_SOF(sof), .USB_RX_BYTE(rxb), .USB_RX_DONE(rxd), .USB_TX_BYTE(txb),
		.USB_TX_SENT(txs), .SYS_DMA_ACK(dack), .CPU_FIFO_ACC(cpu),
		.EP_SMALL_TRANSFER_REQUEST(req[0]), .EP_LARGE_TRANSFER_REQUEST(req[1]),
		.RX_PACKET_READY(rxr), .TX_PACKET_READY(txr), .FIFO_RECOVERY(rec)
	);
	uedr_dma_model PEER (.clk(clk), .rst(rst), .req(req), .dly(dly), .ack(dack));
	// Access count, shortest small request gap, hang limit
	always @(posedge clk)
	begin
		ncyc = ncyc + 1;
		nacc = nacc + dack[0] + dack[1];
		if (req[0] !== 1'b1)
			gap = gap + 1;
		else if (gap > 0)
		begin
			gmin = (gap < gmin) ? gap : gmin;
			gap = 0;
		end
		if (ncyc == 10000)
		begin
			n_fail = n_fail + 1;
			complete_run;
		end
	end
	task complete_run;
	begin
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task check(input [31:0] got, input [31:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			n_fail = n_fail + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// One classic bus cycle, read data left in q
	task wb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wd <= d;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	end
	endtask
	// One-cycle pulse: 0 rx byte, 1 rx done, 2 tx sent, 3 frame start, 4 tx byte, 5 program access
	task pulse(input [2:0] k, input e);
	begin
		@(posedge clk);
		case (k)
			3'd0: rxb[e] <= 1'b1;
			3'd1: rxd[e] <= 1'b1;
			3'd2: txs[e] <= 1'b1;
			3'd4: txb[e] <= 1'b1;
			3'd5: cpu[e] <= 1'b1;
			default: sof <= 1'b1;
		endcase
		@(posedge clk);
		rxb <= 2'h0;
		rxd <= 2'h0;
		txs <= 2'h0;
		txb <= 2'h0;
		cpu <= 2'h0;
		sof <= 1'b0;
	end
	endtask
	// Fresh reset and cleared counters before each scenario
	task start;
	begin
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		nacc = 0;
		gmin = 999;
	end
	endtask
	// Wait until both requests stay low for 40 cycles
	task idle;
		integer n;
	begin
		n = 0;
		while (n < 40)
		begin
			@(posedge clk);
			n = (req === 2'h0) ? n + 1 : 0;
		end
	end
	endtask
	task t_regs;
	begin
		wb(1, 8'h20, 32'h1f);
		wb(1, 8'h08, 32'hffffffff);
		wb(0, 8'h00, 0);
		check(q, 0);
		wb(0, 8'h08, 0);
		check(q, 0);
		wb(0, 8'h2c, 0);
		check(q, 0);
	end
	endtask
	// Program access on a 16-bit endpoint: two bytes out, two clocks of recovery
	task t_cpu;
	begin
		wb(1, 8'h10, 32'h04);
		repeat (4) pulse(0, 1);
		pulse(5, 1);
		@(posedge clk);
		check(32'(rec[1]), 1);
		@(posedge clk);
		check(32'(rec[1]), 1);
		@(posedge clk);
		check(32'(rec[1]), 0);
		wb(0, 8'h18, 0);
		check(q, 32'h0000_0002);
	end
	endtask
	task t_single_tx;
	begin
		dly <= 4'h3;
		wb(1, 8'h04, 32'h14);
		wb(1, 8'h00, 32'h09);
		idle;
		check(nacc, 64);
		check(32'(gmin >= 20), 1);
		check(32'(txr[0]), 1);
		pulse(2, 0);
		repeat (2) @(posedge clk);
		check(32'(txr[0]), 0);
	end
	endtask
	task t_demand_tx;
	begin
		dly <= 4'h0;
		wb(1, 8'h10, 32'h0f);
		idle;
		check(nacc, 128);
		check(32'(txr[1]), 1);
		wb(0, 8'h18, 0);
		check(q, 32'h0002_0100);
		pulse(2, 1);
		repeat (256) pulse(4, 1);
		repeat (2) @(posedge clk);
		check(32'(req[1]), 1);
		idle;
		check(nacc, 256);
		wb(1, 8'h10, 0);
	end
	endtask
	task t_bulk_rx;
	begin
		wb(1, 8'h00, 32'h03);
		repeat (5) pulse(0, 0);
		repeat (4) @(posedge clk);
		check(32'(req[0]), 0);
		pulse(1, 0);
		idle;
		check(nacc, 5);
		check(32'(rxr[0]), 0);
	end
	endtask
	task t_iso_rx;
	begin
		wb(1, 8'h14, 32'hffff);
		wb(1, 8'h10, 32'h11);
		repeat (3) pulse(0, 1);
		pulse(1, 1);
		repeat (4) @(posedge clk);
		check(32'(req[1]), 0);
		pulse(3, 0);
		idle;
		check(nacc, 3);
		check(32'(rxr[1]), 0);
	end
	endtask
	task t_iso_tx;
	begin
		wb(1, 8'h00, 32'h19);
		repeat (4) @(posedge clk);
		check(32'(req[0]), 0);
		pulse(3, 0);
		idle;
		check(nacc, 64);
	end
	endtask
	initial
	begin
		start;
		t_regs;
		start;
		t_cpu;
		start;
		t_single_tx;
		start;
		t_demand_tx;
		start;
		t_bulk_rx;
		start;
		t_iso_rx;
		start;
		t_iso_tx;
		complete_run;
	end
endmodule // testbench
